// file: verilog/acm_pkg.sv
// Package for the converter mode and channel control block.
// Assumes one core clock domain shared with the processor core.
`default_nettype none
package acm_pkg;

  // Control register location and power-on value.
  localparam logic [7:0] ACM_CTRL_ADDR  = 8'hd8;
  localparam logic [7:0] ACM_CTRL_RESET = 8'h00;
  // Bit addresses of the control register share these upper five bits.
  localparam logic [4:0] ACM_CTRL_BITBASE = 5'h1b;

  // Field positions inside the control register.
  localparam int ACM_DONE_BIT  = 7;
  localparam int ACM_DMA_BIT   = 6;
  localparam int ACM_CONT_BIT  = 5;
  localparam int ACM_SINGLE_BIT = 4;
  localparam int ACM_CHAN_MSB  = 3;

  // Channel select codes.
  localparam logic [3:0] ACM_CH_TEMP     = 4'h8;
  localparam logic [3:0] ACM_CH_DAC0     = 4'h9;
  localparam logic [3:0] ACM_CH_DAC1     = 4'ha;
  localparam logic [3:0] ACM_CH_AGND     = 4'hb;
  localparam logic [3:0] ACM_CH_VREF     = 4'hc;
  localparam logic [3:0] ACM_CH_DMA_STOP = 4'hf;

  // Analog multiplexer source picked by a channel code.
  typedef enum logic [2:0] {
    ACM_SRC_INPUT = 3'h0,
    ACM_SRC_TEMP  = 3'h1,
    ACM_SRC_DAC0  = 3'h2,
    ACM_SRC_DAC1  = 3'h3,
    ACM_SRC_AGND  = 3'h4,
    ACM_SRC_VREF  = 3'h5,
    ACM_SRC_NONE  = 3'h6
  } acm_src_t;

  // Conversion sequencer states, Gray coded along the usual path.
  typedef enum logic [1:0] {
    ACM_IDLE  = 2'b00,
    ACM_FETCH = 2'b01,
    ACM_CONV  = 2'b11
  } acm_state_t;

  // Byte access from the core.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } acm_sfr_req_t;

  // Single bit access from the core.
  typedef struct packed {
    logic       wr;
    logic [7:0] bitAddr;
    logic       value;
  } acm_bit_req_t;

  // Channel identifier handed back by the capture memory sequencer.
  typedef struct packed {
    logic       valid;
    logic [3:0] chan;
  } acm_dma_chan_t;

  // Decodes a channel code into the analog source it selects.
  function automatic acm_src_t acm_decode(input logic [3:0] code);
    acm_src_t src;
    src = ACM_SRC_NONE;
    if (code[3] == 1'b0) begin
      src = ACM_SRC_INPUT;
    end else begin
      unique case (code)
        ACM_CH_TEMP: src = ACM_SRC_TEMP;
        ACM_CH_DAC0: src = ACM_SRC_DAC0;
        ACM_CH_DAC1: src = ACM_SRC_DAC1;
        ACM_CH_AGND: src = ACM_SRC_AGND;
        ACM_CH_VREF: src = ACM_SRC_VREF;
        default:     src = ACM_SRC_NONE;
      endcase
    end
    return src;
  endfunction

endpackage
`default_nettype wire

// file: verilog/acm_conv_seq.sv
// Conversion sequencer: single, continuous and block capture modes.
// Assumes the converter core and capture memory run on the same clock.
`timescale 1ns/1ps
`default_nettype none
module acm_conv_seq (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Mode bits from the control register
  input  wire logic              singleReq,
  input  wire logic              contReq,
  input  wire logic              dmaReq,
  input  wire logic [3:0]        chanField,
  // Converter core
  input  wire logic              convDone,
  output logic                   convStart,
  output logic [3:0]             convChan,
  // Capture memory channel fetch
  input  wire acm_pkg::acm_dma_chan_t dmaChan,
  output logic                   dmaFetch,
  // Status towards the control register
  output logic                   busy,
  output logic                   inDma,
  output logic                   singleDone,
  output logic                   dmaEnd
);

  acm_pkg::acm_state_t state_q, state_d;
  logic       dmaMode_q, dmaMode_d;
  logic       single_q, single_d;
  logic       start_q, start_d;
  logic       fetch_q, fetch_d;
  logic [3:0] chan_q, chan_d;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d    = state_q;
    dmaMode_d  = dmaMode_q;
    single_d   = single_q;
    start_d    = 1'b0;
    fetch_d    = 1'b0;
    chan_d     = chan_q;
    singleDone = 1'b0;
    dmaEnd     = 1'b0;
    unique case (state_q)
      acm_pkg::ACM_IDLE: begin
        if (dmaReq) begin
          state_d   = acm_pkg::ACM_FETCH;
          dmaMode_d = 1'b1;
          fetch_d   = 1'b1;
        end else if (singleReq || contReq) begin
          chan_d    = chanField;
          single_d  = singleReq && !contReq;
          start_d   = 1'b1;
          dmaMode_d = 1'b0;
          state_d   = acm_pkg::ACM_CONV;
        end
      end
      acm_pkg::ACM_FETCH: begin
        fetch_d = !dmaChan.valid;
        if (dmaChan.valid) begin
          if (dmaChan.chan == acm_pkg::ACM_CH_DMA_STOP) begin
            dmaEnd    = 1'b1;
            dmaMode_d = 1'b0;
            state_d   = acm_pkg::ACM_IDLE;
          end else begin
            chan_d  = dmaChan.chan;
            start_d = 1'b1;
            state_d = acm_pkg::ACM_CONV;
          end
        end
      end
      acm_pkg::ACM_CONV: begin
        if (convDone) begin
          if (dmaMode_q) begin
            state_d = acm_pkg::ACM_FETCH;
            fetch_d = 1'b1;
          end else if (single_q) begin
            singleDone = 1'b1;
            state_d    = acm_pkg::ACM_IDLE;
          end else if (contReq) begin
            chan_d  = chanField;
            start_d = 1'b1;
          end else begin
            state_d = acm_pkg::ACM_IDLE;
          end
        end
      end
      default: state_d = acm_pkg::ACM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q   <= acm_pkg::ACM_IDLE;
      dmaMode_q <= 1'b0;
      single_q  <= 1'b0;
      start_q   <= 1'b0;
      fetch_q   <= 1'b0;
      chan_q    <= 4'h0;
    end else begin
      state_q   <= state_d;
      dmaMode_q <= dmaMode_d;
      single_q  <= single_d;
      start_q   <= start_d;
      fetch_q   <= fetch_d;
      chan_q    <= chan_d;
    end
  end

  assign convStart = start_q;
  assign convChan  = chan_q;
  assign dmaFetch  = fetch_q;
  assign busy      = (state_q != acm_pkg::ACM_IDLE);
  assign inDma     = dmaMode_q && busy;

endmodule
`default_nettype wire

// file: verilog/acm_mode_ctrl.sv
// Converter mode and channel control register with its sequencer.
// Assumes the core drives byte and bit accesses and the vector
// acknowledge on clk, and that the converter core answers on clk.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - The control register sits at address d8, is bit addressable, and is zero after reset.
// - The done flag in bit 7 is set when a single conversion or a block capture finishes.
// - Vectoring to the converter service routine clears the done flag, otherwise software does.
// - Setting the capture enable in bit 6 runs the configured block capture sequence.
// - The capture enable returns to zero by itself when the capture ends.
// - The address latch strobe stops while capture is enabled and runs again once it starts.
// - The continuous bit in bit 5 makes conversions repeat back to back on the set channel.
// - The single bit in bit 4 requests exactly one conversion on the selected channel, unless the continuous bit is also set.
// - The single bit returns to zero when that conversion completes.
// - Single and continuous conversions use the channel field in bits 3 to 0.
// - In capture mode each channel comes from the identifier read from memory.
// - Codes 0-7 pick inputs, then temperature, two DACs, ground, reference; all ones stops capture.
// - The result high byte carries the converted channel code in its upper four bits.
module acm_mode_ctrl (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // Core register access
  input  wire acm_pkg::acm_sfr_req_t  sfrReq,
  input  wire acm_pkg::acm_bit_req_t  bitReq,
  input  wire logic                   intAck,
  output logic [7:0]                  sfrRdData,
  output logic                        sfrRdHit,
  output logic                        doneFlag,
  // Address latch strobe
  input  wire logic                   aleIn,
  output logic                        aleOut,
  // Converter core
  input  wire logic                   convDone,
  input  wire logic [11:0]            convResult,
  output logic                        convStart,
  output logic [3:0]                  convChan,
  output acm_pkg::acm_src_t           convSrc,
  output logic [7:0]                  resultHigh,
  output logic [7:0]                  resultLow,
  // Capture memory channel fetch
  input  wire acm_pkg::acm_dma_chan_t dmaChan,
  output logic                        dmaFetch
);

  logic [7:0]        ctrl_q, ctrl_d;
  logic [7:0]        rdData_q, rdData_d;
  logic              rdHit_q, rdHit_d;
  logic              ale_q, ale_d;
  logic [7:0]        resHi_q, resHi_d;
  logic [7:0]        resLo_q, resLo_d;
  acm_pkg::acm_src_t src_q, src_d;
  logic              seqBusy, seqDma, singleDone, dmaEnd;
  logic              byteHit, bitHit;

  //////////////////////////////////////////////////////////////////////////
  acm_conv_seq u_seq (
    .clk        (clk),
    .nrst       (nrst),
    .singleReq  (ctrl_q[acm_pkg::ACM_SINGLE_BIT]),
    .contReq    (ctrl_q[acm_pkg::ACM_CONT_BIT]),
    .dmaReq     (ctrl_q[acm_pkg::ACM_DMA_BIT]),
    .chanField  (ctrl_q[acm_pkg::ACM_CHAN_MSB:0]),
    .convDone   (convDone),
    .convStart  (convStart),
    .convChan   (convChan),
    .dmaChan    (dmaChan),
    .dmaFetch   (dmaFetch),
    .busy       (seqBusy),
    .inDma      (seqDma),
    .singleDone (singleDone),
    .dmaEnd     (dmaEnd)
  );

  //////////////////////////////////////////////////////////////////////////
  // Control register: software writes first, hardware events on top.
  assign byteHit = sfrReq.wr && (sfrReq.addr == acm_pkg::ACM_CTRL_ADDR);
  assign bitHit  = bitReq.wr &&
                   (bitReq.bitAddr[7:3] == acm_pkg::ACM_CTRL_BITBASE);

  always_comb begin
    ctrl_d   = ctrl_q;
    rdHit_d  = sfrReq.rd && (sfrReq.addr == acm_pkg::ACM_CTRL_ADDR);
    rdData_d = rdHit_d ? ctrl_q : 8'h00;
    if (byteHit) begin
      ctrl_d = sfrReq.data;
    end else if (bitHit) begin
      ctrl_d[bitReq.bitAddr[2:0]] = bitReq.value;
    end
    if (intAck) begin
      ctrl_d[acm_pkg::ACM_DONE_BIT] = 1'b0;
    end
    if (singleDone) begin
      ctrl_d[acm_pkg::ACM_SINGLE_BIT] = 1'b0;
    end
    if (dmaEnd) begin
      ctrl_d[acm_pkg::ACM_DMA_BIT] = 1'b0;
    end
    if (singleDone || dmaEnd) begin
      ctrl_d[acm_pkg::ACM_DONE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q   <= acm_pkg::ACM_CTRL_RESET;
      rdData_q <= 8'h00;
      rdHit_q  <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      rdData_q <= rdData_d;
      rdHit_q  <= rdHit_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Strobe gating, result capture and source decode.
  always_comb begin
    ale_d   = aleIn && !(ctrl_q[acm_pkg::ACM_DMA_BIT] && !seqDma);
    resHi_d = resHi_q;
    resLo_d = resLo_q;
    src_d   = acm_pkg::acm_decode(convChan);
    if (convDone) begin
      resHi_d = {convChan, convResult[11:8]};
      resLo_d = convResult[7:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ale_q    <= 1'b0;
      resHi_q  <= 8'h00;
      resLo_q  <= 8'h00;
      src_q    <= acm_pkg::ACM_SRC_INPUT;
    end else begin
      ale_q    <= ale_d;
      resHi_q  <= resHi_d;
      resLo_q  <= resLo_d;
      src_q    <= src_d;
    end
  end

  assign sfrRdData  = rdData_q;
  assign sfrRdHit   = rdHit_q;
  assign doneFlag   = ctrl_q[acm_pkg::ACM_DONE_BIT];
  assign aleOut     = ale_q;
  assign convSrc    = src_q;
  assign resultHigh = resHi_q;
  assign resultLow  = resLo_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks on the control register and the sequencer.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_read_ctrl_value: assert property (
    sfrReq.rd && sfrReq.addr == acm_pkg::ACM_CTRL_ADDR
    |=> sfrRdHit && sfrRdData == $past(ctrl_q))
    else $error("control register read returned a wrong value");

  a_flag_single_set: assert property (
    singleDone |=> doneFlag)
    else $error("done flag not set after single conversion");

  a_ack_clears_flag: assert property (
    intAck && !singleDone && !dmaEnd |=> !doneFlag)
    else $error("vector acknowledge did not clear done flag");

  a_dma_end_same: assert property (
    dmaEnd |=> doneFlag && !ctrl_q[acm_pkg::ACM_DMA_BIT])
    else $error("capture end did not clear enable and set flag");

  a_dma_self_clear: assert property (
    dmaEnd && !byteHit |=> ##1 !seqBusy)
    else $error("capture restarted after its end");

  a_ale_stopped: assert property (
    ctrl_q[acm_pkg::ACM_DMA_BIT] && !seqDma |=> !aleOut)
    else $error("strobe toggled while capture armed");

  a_cont_restart: assert property (
    convDone && seqBusy && !seqDma && ctrl_q[acm_pkg::ACM_CONT_BIT]
    |=> convStart)
    else $error("continuous mode did not restart");

  a_single_once: assert property (
    singleDone |=> !ctrl_q[acm_pkg::ACM_SINGLE_BIT] ##1 !convStart)
    else $error("single conversion bit not cleared or reran");

  a_field_channel: assert property (
    !seqBusy && !ctrl_q[acm_pkg::ACM_DMA_BIT] &&
    ctrl_q[acm_pkg::ACM_SINGLE_BIT]
    |=> convStart && convChan == $past(ctrl_q[3:0]))
    else $error("conversion did not use the channel field");

  a_memory_channel: assert property (
    dmaFetch && dmaChan.valid && dmaChan.chan != acm_pkg::ACM_CH_DMA_STOP
    |=> convStart && convChan == $past(dmaChan.chan))
    else $error("capture conversion used the wrong channel");

  a_result_tag: assert property (
    convDone |=> resultHigh[7:4] == $past(convChan))
    else $error("result high byte lacks channel tag");

  // Register access: writes land, misses read zero, flag set only by events or software writes.
  a_write_ctrl_byte: assert property (
    byteHit && !intAck && !singleDone && !dmaEnd
    |=> ctrl_q == $past(sfrReq.data))
    else $error("byte write did not land in the control register");

  a_write_ctrl_bit: assert property (
    bitHit && !byteHit && !intAck && !singleDone && !dmaEnd
    |=> ctrl_q[$past(bitReq.bitAddr[2:0])] == $past(bitReq.value))
    else $error("bit write did not land in the control register");

  a_read_miss_zero: assert property (
    sfrReq.rd && sfrReq.addr != acm_pkg::ACM_CTRL_ADDR
    |=> !sfrRdHit && sfrRdData == 8'h00)
    else $error("read of another address was answered");

  a_flag_only_events: assert property (
    !doneFlag && !singleDone && !dmaEnd && !byteHit && !bitHit
    |=> !doneFlag)
    else $error("done flag set without a finished conversion");

  // Capture mode: start from idle, enable held to the end, strobe back.
  a_capture_starts: assert property (
    !seqBusy && ctrl_q[acm_pkg::ACM_DMA_BIT]
    |=> dmaFetch && seqDma)
    else $error("armed capture did not start from idle");

  a_dma_bit_held: assert property (
    ctrl_q[acm_pkg::ACM_DMA_BIT] && !dmaEnd && !byteHit && !bitHit
    |=> ctrl_q[acm_pkg::ACM_DMA_BIT])
    else $error("capture enable dropped before the capture ended");

  a_ale_follows: assert property (
    seqDma || !ctrl_q[acm_pkg::ACM_DMA_BIT]
    |=> aleOut == $past(aleIn))
    else $error("strobe did not follow its input");

  // Single and continuous conversions.
  a_single_no_rerun: assert property (
    singleDone && !ctrl_q[acm_pkg::ACM_CONT_BIT] &&
    !ctrl_q[acm_pkg::ACM_DMA_BIT] |=> !seqBusy)
    else $error("single conversion was followed by another");

  a_single_bit_held: assert property (
    ctrl_q[acm_pkg::ACM_SINGLE_BIT] && !singleDone && !byteHit && !bitHit
    |=> ctrl_q[acm_pkg::ACM_SINGLE_BIT])
    else $error("single conversion bit dropped too early");

  a_cont_channel: assert property (
    convDone && seqBusy && !seqDma && !ctrl_q[acm_pkg::ACM_SINGLE_BIT] &&
    ctrl_q[acm_pkg::ACM_CONT_BIT] |=> convChan == $past(ctrl_q[3:0]))
    else $error("continuous restart did not use the channel field");

  // Channel decode, result capture and capture end.
  a_src_input: assert property (
    !convChan[3] |=> convSrc == acm_pkg::ACM_SRC_INPUT)
    else $error("input channel code decoded to the wrong source");

  a_src_temp: assert property (
    convChan == acm_pkg::ACM_CH_TEMP
    |=> convSrc == acm_pkg::ACM_SRC_TEMP)
    else $error("temperature code decoded to the wrong source");

  a_src_vref: assert property (
    convChan == acm_pkg::ACM_CH_VREF
    |=> convSrc == acm_pkg::ACM_SRC_VREF)
    else $error("reference code decoded to the wrong source");

  a_src_code_f: assert property (
    convChan == acm_pkg::ACM_CH_DMA_STOP
    |=> convSrc == acm_pkg::ACM_SRC_NONE)
    else $error("all ones code decoded to a source");

  a_result_low: assert property (
    convDone |=> resultLow == $past(convResult[7:0]))
    else $error("result low byte does not hold the result");

  a_result_held: assert property (
    !convDone |=> $stable(resultHigh) && $stable(resultLow))
    else $error("result changed without a finished conversion");

  a_stop_ends: assert property (
    dmaFetch && dmaChan.valid && dmaChan.chan == acm_pkg::ACM_CH_DMA_STOP
    |-> dmaEnd)
    else $error("stop code did not end the capture");

  c_single_run: cover property (
    ctrl_q[acm_pkg::ACM_SINGLE_BIT] ##[1:40] singleDone);
  c_cont_run: cover property (convStart ##[1:40] convStart);
  c_dma_run: cover property (seqDma ##[1:80] dmaEnd);
  c_ack_flag: cover property (doneFlag ##1 intAck);

endmodule
`default_nettype wire

// file: verif/acm_far_model.sv
// Far-side model: converter core and capture memory channel list.
// Assumes the block under test shares clk and nrst with this model.
`timescale 1ns/1ps
`default_nettype none
module acm_far_model (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Answer delay and capture channel list
  input  wire logic [2:0]        lat,
  input  wire logic [15:0]       dmaSeq,
  // Converter core side
  input  wire logic              convStart,
  output logic                   convDone,
  output logic [11:0]            convResult,
  // Capture memory side
  input  wire logic              dmaFetch,
  output acm_pkg::acm_dma_chan_t dmaChan
);
  logic [3:0]  cnt;
  logic [2:0]  fetchWait;
  logic [1:0]  idx;
  logic [3:0]  lastChan;
  logic        chanValid;
  logic [11:0] noise;

  // The result bus changes every cycle, so only the done cycle carries data.
  assign convResult = noise;
  assign dmaChan = '{valid: chanValid,
                     chan: chanValid ? lastChan : ~lastChan};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt       <= 4'h0;
      convDone  <= 1'b0;
      noise     <= 12'h5a3;
      fetchWait <= 3'h0;
      idx       <= 2'h0;
      lastChan  <= 4'h0;
      chanValid <= 1'b0;
    end else begin
      noise    <= {noise[10:0], noise[11] ^ noise[5]};
      convDone <= (cnt == 4'h1);
      if (convStart) begin
        cnt <= {1'b0, lat} + 4'h2;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
      if (dmaFetch && !chanValid) begin
        if (fetchWait == lat) begin
          chanValid <= 1'b1;
          fetchWait <= 3'h0;
          lastChan  <= dmaSeq[{~idx, 2'b00} +: 4];
          idx       <= (dmaSeq[{~idx, 2'b00} +: 4] == 4'hf) ? 2'h0 : idx + 2'h1;
        end else begin
          fetchWait <= fetchWait + 3'h1;
        end
      end else begin
        chanValid <= 1'b0;
        fetchWait <= 3'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/acm_mode_ctrl_tb_top.sv
// Self-checking bench for the converter mode and channel control block.
// Assumes the far-side model stands in for converter and capture memory.
`timescale 1ns/1ps
`default_nettype none
module acm_mode_ctrl_tb_top;
  localparam logic [7:0] CTRL = acm_pkg::ACM_CTRL_ADDR;
  logic                   clk = 1'b0;
  logic                   nrst = 1'b0;
  acm_pkg::acm_sfr_req_t  sfrReq = '0;
  acm_pkg::acm_bit_req_t  bitReq = '0;
  logic                   intAck = 1'b0;
  logic                   aleIn = 1'b0;
  logic                   aleHold = 1'b0;
  logic [2:0]             lat = 3'h0;
  logic [15:0]            dmaSeq = 16'h3a1f;
  logic                   convDone, convStart, sfrRdHit;
  logic                   doneFlag, aleOut, dmaFetch, prevAle;
  logic [11:0]            convResult, lastRes;
  logic [3:0]             convChan;
  logic [7:0]             sfrRdData, resultHigh, resultLow;
  acm_pkg::acm_src_t      convSrc;
  acm_pkg::acm_dma_chan_t dmaChan;
  logic [31:0]            seed = 32'he2af;
  logic [7:0]             aleCnt = 8'h0;
  logic [3:0]             chans[$];
  int                     nStart = 0;
  int                     nLow = 0;
  int                     nErrors = 0;
  int                     compares = 0;

  always #25 clk = ~clk;

  acm_mode_ctrl u_dut (.clk(clk), .nrst(nrst), .sfrReq(sfrReq),
    .bitReq(bitReq), .intAck(intAck), .sfrRdData(sfrRdData),
    .sfrRdHit(sfrRdHit), .doneFlag(doneFlag), .aleIn(aleIn),
    .aleOut(aleOut), .convDone(convDone), .convResult(convResult),
    .convStart(convStart), .convChan(convChan), .convSrc(convSrc),
    .resultHigh(resultHigh), .resultLow(resultLow), .dmaChan(dmaChan),
    .dmaFetch(dmaFetch));

  acm_far_model u_far (.clk(clk), .nrst(nrst), .lat(lat), .dmaSeq(dmaSeq),
    .convStart(convStart), .convDone(convDone), .convResult(convResult),
    .dmaFetch(dmaFetch), .dmaChan(dmaChan));

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    aleCnt <= aleCnt + 8'h1;
    aleIn <= #1 aleHold | (aleCnt[0] ^ aleCnt[2]);
    prevAle <= aleIn;
    if (convDone) lastRes <= convResult;
    if (convStart) nStart <= nStart + 1;
    if (convStart) chans.push_back(convChan);
    if (aleHold && !aleOut) nLow <= nLow + 1;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [2:0] expSrc(input logic [3:0] c);
    if (c < 4'h8) return 3'h0;
    if (c > 4'hc) return 3'h6;
    return 3'(c - 4'h7);
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic byteWr(input logic [7:0] a, input logic [7:0] d);
    sfrReq = '{1'b1, 1'b0, a, d};
    tick;
    sfrReq = '0;
    tick;
  endtask

  task automatic byteRd(input logic [7:0] a, input logic [7:0] e,
                        input logic hit);
    sfrReq = '{1'b0, 1'b1, a, 8'h00};
    tick;
    chk(sfrRdData, e);
    chk(sfrRdHit, hit);
    sfrReq = '0;
    tick;
  endtask

  task automatic bitWr(input logic [7:0] a, input logic v);
    bitReq = '{1'b1, a, v};
    tick;
    bitReq = '0;
    tick;
  endtask

  task automatic end_sim;
    $display("errors %0d compares %0d", nErrors, compares);
    if (nErrors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    end_sim;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] a;
    int n0;
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    byteRd(CTRL, 8'h00, 1'b1);
    seed = xs(seed);
    a = (seed[7:0] == CTRL) ? 8'h00 : seed[7:0];
    byteWr(a, 8'hff);
    byteRd(a, 8'h00, 1'b0);
    byteRd(CTRL, 8'h00, 1'b1);
    for (int c = 0; c < 16; c++) begin
      seed = xs(seed);
      lat = seed[2:0];
      n0 = nStart;
      byteWr(CTRL, {4'h1, c[3:0]});
      chk(convChan, c[3:0]);
      tick;
      chk(convSrc, expSrc(c[3:0]));
      for (int i = 0; i < 64 && !doneFlag; i++) tick;
      chk(resultHigh, {c[3:0], lastRes[11:8]});
      chk(resultLow, lastRes[7:0]);
      byteRd(CTRL, {4'h8, c[3:0]}, 1'b1);
      chk(16'(nStart - n0), 16'h1);
      if (c[0]) begin
        intAck = 1'b1;
        tick;
        intAck = 1'b0;
        tick;
      end else bitWr(8'hdf, 1'b0);
      chk(doneFlag, 1'b0);
    end
    lat = 3'h7;
    n0 = nStart;
    byteWr(CTRL, 8'h26);
    for (int i = 0; i < 200 && nStart < n0 + 3; i++) tick;
    bitWr(8'hdd, 1'b0);
    repeat (30) tick;
    chk(16'(nStart - n0), 16'h3);
    chk(convChan, 4'h6);
    byteRd(CTRL, 8'h06, 1'b1);
    nrst = 1'b0;
    tick;
    nrst = 1'b1;
    byteRd(CTRL, 8'h00, 1'b1);
    for (int k = 0; k < 2; k++) begin
      lat = k[0] ? 3'h0 : 3'h5;
      aleHold = 1'b1;
      repeat (3) tick;
      nLow = 0;
      chans.delete();
      byteWr(CTRL, 8'h45);
      repeat (2) tick;
      aleHold = 1'b0;
      chk(16'(nLow != 0), 16'h1);
      chk(aleOut, 1'b1);
      for (int i = 0; i < 200 && !doneFlag; i++) tick;
      byteRd(CTRL, 8'h85, 1'b1);
      chk(16'(chans.size()), 16'h3);
      for (int i = 0; i < 3 && i < chans.size(); i++)
        chk(chans[i], dmaSeq[15 - 4 * i -: 4]);
      repeat (4) begin
        tick;
        chk(aleOut, prevAle);
      end
      bitWr(8'hdf, 1'b0);
    end
    end_sim;
  end
endmodule
`default_nettype wire
